// ===== hdl/pbtc_pkg.sv
package pbtc_pkg;

  // Register byte offsets
  localparam logic [7:0] PBTC_CTRL_OFS = 8'h00;
  localparam logic [7:0] PBTC_STATUS_OFS = 8'h04;
  localparam logic [7:0] PBTC_PRESET_OFS = 8'h08;
  localparam logic [7:0] PBTC_EVENTS_OFS = 8'h0C;

  // Control register bit positions, all write-only pulses
  localparam int PBTC_CTRL_START_BIT = 0;
  localparam int PBTC_CTRL_HALT_BIT = 1;
  localparam int PBTC_CTRL_CLEAR_BIT = 2;

  // Status register field positions
  localparam int PBTC_ST_COUNT_LSB = 0;
  localparam int PBTC_ST_PRESET_LSB = 8;
  localparam int PBTC_ST_RUN_BIT = 16;
  localparam int PBTC_ST_MATCH_BIT = 17;
  localparam int PBTC_ST_LOAD_BIT = 18;
  localparam int PBTC_ST_SCAN_BIT = 19;
  localparam int PBTC_ST_CARRY_BIT = 20;

  // Event register bit positions, write one to clear
  localparam int PBTC_EV_WRAP_BIT = 0;
  localparam int PBTC_EV_MATCH_BIT = 1;

  // Reset values
  localparam logic [3:0] PBTC_DIGIT_RST = 4'h0;
  localparam logic [6:0] PBTC_SEG_RST = 7'h7F;
  localparam logic PBTC_CARRY_RST = 1'b1;

  // BCD limits
  localparam logic [3:0] PBTC_DIGIT_MAX = 4'h9;
  localparam logic [3:0] PBTC_DIGIT_ONE = 4'h1;

  // Timing: carry stays low this long after a wrap
  localparam int PBTC_CLK_PERIOD_NS = 10;
  localparam int PBTC_CARRY_LOW_NS = 40;
  localparam int PBTC_CARRY_LOW_CYC =
    (PBTC_CARRY_LOW_NS + PBTC_CLK_PERIOD_NS - 1) / PBTC_CLK_PERIOD_NS;
  localparam int PBTC_SYNC_STAGES = 2;

  // Run flip-flop state
  typedef enum logic [0:0] {
    PBTC_STOPPED = 1'b0,
    PBTC_RUNNING = 1'b1
  } pbtc_run_e;

  // Pin inputs of the counter
  typedef struct packed {
    logic start;
    logic halt;
    logic clear_n;
    logic count_n;
    logic scan;
    logic load_n;
    logic [3:0] prog_n;
  } pbtc_pins_in_s;

  localparam int PBTC_PIN_IN_W = 10;

  // Idle pin levels in struct order: no start, no halt, no clear, count high,
  // ones scanned, no load, program data all high
  localparam logic [PBTC_PIN_IN_W-1:0] PBTC_PIN_IDLE = 10'h0FF;

  // Pin outputs of the counter
  typedef struct packed {
    logic run;
    logic carry;
    logic match;
    logic [6:0] seg_n;
    logic ones_strobe_n;
    logic tens_strobe_n;
  } pbtc_pins_out_s;

endpackage : pbtc_pkg

// ===== hdl/pbtc_seg_decoder.sv
`timescale 1ns/10ps
module pbtc_seg_decoder (
  input wire logic [3:0] digit,
  output logic [6:0] seg_n
);
  import pbtc_pkg::*;

  // Bit order g f e d c b a; codes above nine blank the digit
  always_comb begin
    unique case (digit)
      4'h0: seg_n = 7'h40;
      4'h1: seg_n = 7'h79;
      4'h2: seg_n = 7'h24;
      4'h3: seg_n = 7'h30;
      4'h4: seg_n = 7'h19;
      4'h5: seg_n = 7'h12;
      4'h6: seg_n = 7'h02;
      4'h7: seg_n = 7'h78;
      4'h8: seg_n = 7'h00;
      4'h9: seg_n = 7'h10;
      default: seg_n = PBTC_SEG_RST;
    endcase
  end

endmodule : pbtc_seg_decoder

// ===== hdl/pbtc_top.sv
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module pbtc_top #(
  parameter int SYNC_STAGES = pbtc_pkg::PBTC_SYNC_STAGES,
  parameter int CARRY_LOW_CYC = pbtc_pkg::PBTC_CARRY_LOW_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire pbtc_pkg::pbtc_pins_in_s pins_in,
  output pbtc_pkg::pbtc_pins_out_s pins_out
);
  import pbtc_pkg::*;

  localparam int CW = (CARRY_LOW_CYC > 1) ? $clog2(CARRY_LOW_CYC + 1) : 1;

  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end
  if (CARRY_LOW_CYC < 1) begin : g_bad_carry
    $error("CARRY_LOW_CYC must be at least 1");
  end

  // Pin synchronisers; only the last stage is read by logic
  // Chains reset to idle levels so no false clear, load or count edge follows reset
  logic [PBTC_PIN_IN_W-1:0] pin_raw;
  logic [PBTC_PIN_IN_W-1:0] pin_sync;
  logic [SYNC_STAGES-1:0] sync_chain_reg [PBTC_PIN_IN_W];
  assign pin_raw = pins_in;

  for (genvar i = 0; i < PBTC_PIN_IN_W; i++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sync_chain_reg[i] <= {SYNC_STAGES{PBTC_PIN_IDLE[i]}};
      end else begin
        sync_chain_reg[i] <= {sync_chain_reg[i][SYNC_STAGES-2:0], pin_raw[i]};
      end
    end
    assign pin_sync[i] = sync_chain_reg[i][SYNC_STAGES-1];
  end

  pbtc_pins_in_s pin_s;
  assign pin_s = pin_sync;

  // AHB-Lite slave, zero wait states
  logic accept;
  logic dp_write_reg;
  logic [7:0] dp_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] read_value;
  logic wr_ctrl;
  logic wr_preset;
  logic wr_events;

  assign accept = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign wr_ctrl = dp_write_reg && (dp_addr_reg == PBTC_CTRL_OFS);
  assign wr_preset = dp_write_reg && (dp_addr_reg == PBTC_PRESET_OFS);
  assign wr_events = dp_write_reg && (dp_addr_reg == PBTC_EVENTS_OFS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
    end else begin
      dp_write_reg <= accept && hwrite;
      dp_addr_reg <= accept ? {haddr[7:2], 2'b00} : dp_addr_reg;
    end
  end

  // Read data is registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (accept && !hwrite) begin
      hrdata_reg <= read_value;
    end
  end

  // Software control pulses, held one cycle
  logic sw_start;
  logic sw_halt;
  logic sw_clear;
  assign sw_start = wr_ctrl && hwdata[PBTC_CTRL_START_BIT];
  assign sw_halt = wr_ctrl && hwdata[PBTC_CTRL_HALT_BIT];
  assign sw_clear = wr_ctrl && hwdata[PBTC_CTRL_CLEAR_BIT];

  logic do_start;
  logic do_halt;
  logic do_clear;
  assign do_start = pin_s.start || sw_start;
  assign do_halt = pin_s.halt || sw_halt;
  assign do_clear = !pin_s.clear_n || sw_clear;

  // Run flip-flop
  pbtc_run_e run_reg;
  pbtc_run_e run_next;

  always_comb begin
    run_next = run_reg;
    if (do_clear) begin
      run_next = PBTC_STOPPED;
    end else if (do_halt) begin
      run_next = PBTC_STOPPED;
    end else if (do_start) begin
      run_next = PBTC_RUNNING;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= PBTC_STOPPED;
    end else begin
      run_reg <= run_next;
    end
  end

  // Count input falling edge, seen on the synchronised level
  // A pin fall reaches the counter about three clocks later
  logic count_d_reg;
  logic count_fall;
  logic count_step;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_d_reg <= 1'b1;
    end else begin
      count_d_reg <= pin_s.count_n;
    end
  end

  assign count_fall = count_d_reg && !pin_s.count_n;
  assign count_step = count_fall && (run_reg == PBTC_RUNNING);

  // Two BCD digits
  logic [3:0] ones_reg;
  logic [3:0] tens_reg;
  logic ones_top;
  logic tens_top;
  logic wrap;

  assign ones_top = (ones_reg == PBTC_DIGIT_MAX);
  assign tens_top = (tens_reg == PBTC_DIGIT_MAX);
  assign wrap = count_step && ones_top && tens_top && !do_clear;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ones_reg <= PBTC_DIGIT_RST;
      tens_reg <= PBTC_DIGIT_RST;
    end else if (do_clear) begin
      ones_reg <= PBTC_DIGIT_RST;
      tens_reg <= PBTC_DIGIT_RST;
    end else if (count_step) begin
      if (ones_top) begin
        ones_reg <= PBTC_DIGIT_RST;
        tens_reg <= tens_top ? PBTC_DIGIT_RST : tens_reg + PBTC_DIGIT_ONE;
      end else begin
        ones_reg <= ones_reg + PBTC_DIGIT_ONE;
      end
    end
  end

  // Carry idles high and drops for a short stretch per wrap, so the next stage
  // sees exactly one falling edge; clearing this stage never disturbs it
  logic carry_reg;
  logic [CW-1:0] carry_cnt_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carry_reg <= PBTC_CARRY_RST;
      carry_cnt_reg <= '0;
    end else if (wrap) begin
      carry_reg <= 1'b0;
      carry_cnt_reg <= CW'(CARRY_LOW_CYC - 1);
    end else if (carry_cnt_reg != '0) begin
      carry_cnt_reg <= carry_cnt_reg - CW'(1);
    end else begin
      carry_reg <= 1'b1;
    end
  end

  // Preset latch
  logic loading;
  logic [3:0] prog_digit;
  logic [3:0] preset_ones_reg;
  logic [3:0] preset_tens_reg;

  assign loading = !pin_s.load_n;
  assign prog_digit = ~pin_s.prog_n;

  // Pin load wins over a software write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preset_ones_reg <= PBTC_DIGIT_RST;
      preset_tens_reg <= PBTC_DIGIT_RST;
    end else if (loading) begin
      if (pin_s.scan) begin
        preset_ones_reg <= prog_digit;
      end else begin
        preset_tens_reg <= prog_digit;
      end
    end else if (wr_preset) begin
      preset_ones_reg <= hwdata[3:0];
      preset_tens_reg <= hwdata[7:4];
    end
  end

  // Comparator
  logic match_reg;
  logic match_next;
  assign match_next = !loading && (ones_reg == preset_ones_reg) &&
    (tens_reg == preset_tens_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= match_next;
    end
  end

  // Display multiplexer
  logic [3:0] shown_digit;
  logic [6:0] seg_dec;
  logic [6:0] seg_n_reg;
  logic ones_strobe_n_reg;
  logic tens_strobe_n_reg;

  assign shown_digit = pin_s.scan ? ones_reg : tens_reg;

  pbtc_seg_decoder u_seg (
    .digit(shown_digit),
    .seg_n(seg_dec)
  );

  // Segments and strobes come from the same edge so digits never ghost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seg_n_reg <= PBTC_SEG_RST;
      ones_strobe_n_reg <= 1'b1;
      tens_strobe_n_reg <= 1'b1;
    end else begin
      seg_n_reg <= seg_dec;
      ones_strobe_n_reg <= !pin_s.scan;
      tens_strobe_n_reg <= pin_s.scan;
    end
  end

  // Sticky events; a set in the clearing cycle wins
  logic ev_wrap_reg;
  logic ev_match_reg;
  logic match_rise;
  assign match_rise = match_next && !match_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_wrap_reg <= 1'b0;
    end else if (wrap) begin
      ev_wrap_reg <= 1'b1;
    end else if (wr_events && hwdata[PBTC_EV_WRAP_BIT]) begin
      ev_wrap_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_match_reg <= 1'b0;
    end else if (match_rise) begin
      ev_match_reg <= 1'b1;
    end else if (wr_events && hwdata[PBTC_EV_MATCH_BIT]) begin
      ev_match_reg <= 1'b0;
    end
  end

  // Register read mux; unmapped offsets read zero
  always_comb begin
    read_value = 32'h0000_0000;
    unique case ({haddr[7:2], 2'b00})
      PBTC_STATUS_OFS: begin
        read_value[PBTC_ST_COUNT_LSB +: 8] = {tens_reg, ones_reg};
        read_value[PBTC_ST_PRESET_LSB +: 8] = {preset_tens_reg, preset_ones_reg};
        read_value[PBTC_ST_RUN_BIT] = (run_reg == PBTC_RUNNING);
        read_value[PBTC_ST_MATCH_BIT] = match_reg;
        read_value[PBTC_ST_LOAD_BIT] = loading;
        read_value[PBTC_ST_SCAN_BIT] = pin_s.scan;
        read_value[PBTC_ST_CARRY_BIT] = carry_reg;
      end
      PBTC_PRESET_OFS: begin
        read_value[7:0] = {preset_tens_reg, preset_ones_reg};
      end
      PBTC_EVENTS_OFS: begin
        read_value[PBTC_EV_WRAP_BIT] = ev_wrap_reg;
        read_value[PBTC_EV_MATCH_BIT] = ev_match_reg;
      end
      default: begin
        read_value = 32'h0000_0000;
      end
    endcase
  end

  // Pin outputs
  always_comb begin
    pins_out.run = (run_reg == PBTC_RUNNING);
    pins_out.carry = carry_reg;
    pins_out.match = match_reg;
    pins_out.seg_n = seg_n_reg;
    pins_out.ones_strobe_n = ones_strobe_n_reg;
    pins_out.tens_strobe_n = tens_strobe_n_reg;
  end

endmodule : pbtc_top

// ===== tb/pbtc_ext_ctl.sv
`timescale 1ns/10ps
module pbtc_ext_ctl #(
  parameter int CNT_HALF = 50,
  parameter int SCAN_HOLD = 8
) (
  input wire logic hclk,
  output pbtc_pkg::pbtc_pins_in_s pins_in
);
  import pbtc_pkg::*;
  initial begin
    pins_in = 10'h0FF;
  end
  // Half period of 50 cycles keeps the count input at 1 MHz
  task automatic pulse(input int n);
    repeat (2 * n) begin
      repeat (CNT_HALF) @(posedge hclk);
      pins_in.count_n <= ~pins_in.count_n;
    end
  endtask : pulse
  // Scan toggles far faster than the pin limit so runs stay short
  task automatic set_scan(input logic s);
    pins_in.scan <= s;
    repeat (SCAN_HOLD) @(posedge hclk);
  endtask : set_scan
  task automatic load(input int ones, input int tens);
    pins_in.load_n <= 1'b0;
    pins_in.prog_n <= ~4'(ones);
    set_scan(1'b1);
    pins_in.prog_n <= ~4'(tens);
    set_scan(1'b0);
    pins_in.load_n <= 1'b1;
    set_scan(1'b1);
  endtask : load
  task automatic ctl(input logic st, input logic hl, input logic cl_n);
    pins_in.start <= st;
    pins_in.halt <= hl;
    pins_in.clear_n <= cl_n;
    repeat (SCAN_HOLD) @(posedge hclk);
    pins_in.start <= 1'b0;
    pins_in.halt <= 1'b0;
    pins_in.clear_n <= 1'b1;
    repeat (SCAN_HOLD) @(posedge hclk);
  endtask : ctl
endmodule : pbtc_ext_ctl

// ===== tb/pbtc_sva.sv
`timescale 1ns/10ps
module pbtc_sva #(
  parameter int CARRY_LOW_CYC = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire pbtc_pkg::pbtc_pins_in_s pins_in,
  input wire pbtc_pkg::pbtc_pins_out_s pins_out
);
  import pbtc_pkg::*;
  int low_cnt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Counts sampled low cycles of carry so its stretch length can be judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= pins_out.carry ? 0 : low_cnt + 1;
    end
  end
  property p_start;
    (pins_in.start && !pins_in.halt && pins_in.clear_n)[*4] |-> ##1 pins_out.run;
  endproperty
  a_start: assert property (p_start) else $error("run not set");
  property p_halt;
    pins_in.halt[*4] |-> ##1 !pins_out.run;
  endproperty
  a_halt: assert property (p_halt) else $error("run not stopped");
  property p_clear;
    !pins_in.clear_n[*4] |-> ##1 !pins_out.run;
  endproperty
  a_clear: assert property (p_clear) else $error("run not cleared");
  property p_scan_hi;
    pins_in.scan[*4] |-> ##1 (!pins_out.ones_strobe_n && pins_out.tens_strobe_n);
  endproperty
  a_scan_hi: assert property (p_scan_hi) else $error("ones strobe wrong");
  property p_scan_lo;
    !pins_in.scan[*4] |-> ##1 (pins_out.ones_strobe_n && !pins_out.tens_strobe_n);
  endproperty
  a_scan_lo: assert property (p_scan_lo) else $error("tens strobe wrong");
  property p_load;
    !pins_in.load_n[*4] |-> ##1 !pins_out.match;
  endproperty
  a_load: assert property (p_load) else $error("match during load");
  property p_carry_run;
    $fell(pins_out.carry) |-> $past(pins_out.run);
  endproperty
  a_carry_run: assert property (p_carry_run) else $error("carry while stopped");
  // Catches both a short and a long carry stretch
  property p_carry_len;
    $rose(pins_out.carry) |-> low_cnt == CARRY_LOW_CYC;
  endproperty
  a_carry_len: assert property (p_carry_len) else $error("carry length wrong");
  property p_carry_max;
    low_cnt <= CARRY_LOW_CYC;
  endproperty
  a_carry_max: assert property (p_carry_max) else $error("carry stuck low");
endmodule : pbtc_sva

bind pbtc_top pbtc_sva #(.CARRY_LOW_CYC(CARRY_LOW_CYC)) pbtc_sva_inst (.hclk(hclk),
  .hresetn(hresetn), .pins_in(pins_in), .pins_out(pins_out));

// ===== tb/pbtc_tb_top.sv
`timescale 1ns/10ps
module pbtc_tb_top;
  import pbtc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  pbtc_pins_in_s pins_in;
  pbtc_pins_out_s po;
  int mismatches, n_tests, cnt, pre, falls, n;
  logic run;
  logic [6:0] seg_tab [10] = '{7'h40, 7'h79, 7'h24, 7'h30, 7'h19, 7'h12, 7'h02, 7'h78,
    7'h00, 7'h10};
  pbtc_top pbtc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .pins_in(pins_in), .pins_out(po));
  pbtc_ext_ctl pbtc_ext_ctl_inst (.hclk(hclk), .pins_in(pins_in));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(negedge po.carry) falls++;
  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction : bcd
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      chk(0, 1);
      end_of_test();
    end
  endtask : wait_rdy
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  // Model: match is only meaningful while no load is running
  task automatic chk_st;
    bus(1'b0, PBTC_STATUS_OFS, 0);
    chk(32'(rd[17:0]), 32'({cnt == pre, run, bcd(pre), bcd(cnt)}));
    chk(32'({po.run, po.match}), 32'({run, cnt == pre}));
  endtask : chk_st
  task automatic show;
    for (int s = 0; s < 2; s++) begin
      pbtc_ext_ctl_inst.set_scan(s[0]);
      chk(32'(po.seg_n), 32'(seg_tab[s ? cnt % 10 : cnt / 10]));
      chk(32'({po.ones_strobe_n, po.tens_strobe_n}), s ? 1 : 2);
    end
  endtask : show
  initial begin
    repeat (90000) @(posedge hclk);
    chk(0, 1);
    end_of_test();
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    void'($urandom(45853));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
    {cnt, pre, run} = '0;
    chk_st();
    show();
    bus(1'b0, 8'h10, 0);
    chk(rd, 0);
    $display("test reset done");
    pre = $urandom_range(99);
    pbtc_ext_ctl_inst.load(pre % 10, pre / 10);
    chk_st();
    pbtc_ext_ctl_inst.ctl(1'b1, 1'b0, 1'b1);
    run = 1'b1;
    n = $urandom_range(1, 20);
    pbtc_ext_ctl_inst.pulse(n);
    cnt = n % 100;
    chk_st();
    show();
    pbtc_ext_ctl_inst.pulse((pre - cnt + 100) % 100);
    cnt = pre;
    chk_st();
    $display("test count done");
    pbtc_ext_ctl_inst.ctl(1'b1, 1'b1, 1'b1);
    run = 1'b0;
    pbtc_ext_ctl_inst.pulse(2);
    chk_st();
    pbtc_ext_ctl_inst.ctl(1'b1, 1'b0, 1'b1);
    run = 1'b1;
    falls = 0;
    pbtc_ext_ctl_inst.pulse(101 - cnt);
    cnt = 1;
    chk_st();
    chk(falls, 1);
    bus(1'b0, PBTC_EVENTS_OFS, 0);
    chk(rd, 32'h3);
    bus(1'b1, PBTC_EVENTS_OFS, 32'h3);
    bus(1'b0, PBTC_EVENTS_OFS, 0);
    chk(rd, 32'h0);
    bus(1'b1, PBTC_CTRL_OFS, 32'h4);
    {cnt, run} = '0;
    chk_st();
    pbtc_ext_ctl_inst.ctl(1'b1, 1'b0, 1'b1);
    run = 1'b1;
    pbtc_ext_ctl_inst.pulse(1);
    cnt = 1;
    chk_st();
    pbtc_ext_ctl_inst.ctl(1'b0, 1'b0, 1'b0);
    {cnt, run} = '0;
    chk_st();
    $display("test wrap done");
    pre = $urandom_range(99);
    bus(1'b1, PBTC_PRESET_OFS, 32'(bcd(pre)));
    bus(1'b0, PBTC_PRESET_OFS, 0);
    chk(rd, 32'(bcd(pre)));
    bus(1'b1, PBTC_CTRL_OFS, 1);
    run = 1'b1;
    chk_st();
    bus(1'b1, PBTC_CTRL_OFS, 32'h2);
    run = 1'b0;
    chk_st();
    $display("test regs done");
    end_of_test();
  end
endmodule : pbtc_tb_top
